// ===== rtl/bcdadj_consts.svh
`ifndef BCDADJ_CONSTS_SVH
`define BCDADJ_CONSTS_SVH
`define BCDADJ_OPC_ADJ 16'h0007
`define BCDADJ_OPC_DEC_MASK 16'hFC00
`define BCDADJ_OPC_DEC_BITS 16'h0400
`define BCDADJ_DEST_BIT 9
`define BCDADJ_BANK_BIT 8
`define BCDADJ_NIB_LIMIT 4'h9
`define BCDADJ_NIB_FIX 4'h6
`define BCDADJ_ACCESS_BANK 4'h0
`define BCDADJ_W_RST 8'h00
`define BCDADJ_FLAGS_RST 5'h00
`endif

// ===== rtl/bcdadj_pkg.sv
package bcdadj_pkg;
    typedef enum logic [1:0] {
        BCDADJ_Q1 = 2'b00,
        BCDADJ_Q2 = 2'b01,
        BCDADJ_Q3 = 2'b10,
        BCDADJ_Q4 = 2'b11
    } bcdadj_phase_e;
    typedef enum logic [1:0] {
        BCDADJ_OP_NONE = 2'b00,
        BCDADJ_OP_ADJ = 2'b01,
        BCDADJ_OP_DEC = 2'b10
    } bcdadj_op_e;
endpackage : bcdadj_pkg

// ===== rtl/bcdadj_phase_gen.sv
`timescale 1ns/10ps
module bcdadj_phase_gen
    import bcdadj_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic arst_n, // Async reset, active low
    output bcdadj_pkg::bcdadj_phase_e phase // Current phase
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= BCDADJ_Q1;
        end else begin
            case (phase)
                BCDADJ_Q1: phase <= BCDADJ_Q2;
                BCDADJ_Q2: phase <= BCDADJ_Q3;
                BCDADJ_Q3: phase <= BCDADJ_Q4;
                BCDADJ_Q4: phase <= BCDADJ_Q1;
                default: phase <= BCDADJ_Q1;
            endcase
        end
    end
endmodule : bcdadj_phase_gen

// ===== rtl/bcdadj_unit.sv
// Functional notes
// - Low nibble above 9 or digit carry set adds 6 to it.
// - High nibble above 9 or carry set adds 6 to it.
// - Decimal adjust has no operands and fixes working register to BCD.
// - One instruction cycle: decode, read, compute, write working register or data byte.
// - Decimal adjust opcode is exactly 16'h0007.
// - Decrement subtracts one; dest bit 0 to working register, 1 to byte.
// - Decrement sets all five flags; decimal adjust changes carry only.
// - Bank bit 0 uses access bank; 1 uses the bank pointer register.
`timescale 1ns/10ps
`include "bcdadj_consts.svh"
module bcdadj_unit
    import bcdadj_pkg::*;
#(
    parameter int ADDR_W = 12 // Data memory address width
) (
    input wire logic clk, // Core clock, 40 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic [15:0] opcode, // Instruction word, held over the cycle
    input wire logic [3:0] bank_pointer_register, // Bank pointer value
    input wire logic [7:0] mem_rdata, // Data memory read data
    output logic [ADDR_W-1:0] mem_addr, // Data memory address
    output logic mem_we, // Data memory write strobe
    output logic [7:0] mem_wdata, // Data memory write data
    output logic [7:0] wreg, // Working register
    output logic carry_flag, // Carry / not-borrow
    output logic digit_carry_flag, // Digit carry / not-borrow
    output logic negative_flag, // Negative
    output logic signed_wrap_flag, // Signed overflow
    output logic zero_flag, // Zero
    output bcdadj_pkg::bcdadj_phase_e phase // Current phase
);
    import bcdadj_pkg::*;

    // Each phase keeps its own register, so no path spans more than one
    // step of the instruction. The cost is a few flops of staging, which
    // is small next to the timing margin it buys at the core clock.
    bcdadj_op_e op;
    logic [7:0] operand;
    logic [7:0] result;
    logic [4:0] res_flags;
    logic dest_byte;
    logic next_mem_we;
    logic [ADDR_W-1:0] next_mem_addr;
    logic [8:0] adj_fix;

    // A nibble needs the correction when it is no decimal digit, or when
    // the flag says the preceding addition already carried out of it.
    function automatic logic nib_fix(input logic [3:0] nib, input logic flag);
        nib_fix = (nib > `BCDADJ_NIB_LIMIT) || flag;
    endfunction : nib_fix

    // Only the exact adjust word is accepted. Every word outside the
    // decrement group, other than the adjust word, decodes to no operation and leaves the working register, flags and memory alone.
    function automatic bcdadj_op_e decode_op(input logic [15:0] word);
        if (word == `BCDADJ_OPC_ADJ) begin
            decode_op = BCDADJ_OP_ADJ;
        end else if ((word & `BCDADJ_OPC_DEC_MASK)
                     == `BCDADJ_OPC_DEC_BITS) begin
            decode_op = BCDADJ_OP_DEC;
        end else begin
            decode_op = BCDADJ_OP_NONE;
        end
    endfunction : decode_op

    // The low nibble's correction may carry into the high nibble. That
    // carry is folded in before the high nibble is tested, so a sum whose
    // low digit overflows still ends as a valid packed BCD value. Bit 8 of
    // the answer is the carry out of the high nibble.
    function automatic logic [8:0] adj_calc(input logic [7:0] val,
                                            input logic c_in,
                                            input logic dc_in);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, val[3:0]};
        hi = {1'b0, val[7:4]};
        if (nib_fix(val[3:0], dc_in)) begin
            lo = lo + {1'b0, `BCDADJ_NIB_FIX};
        end
        hi = hi + {4'h0, lo[4]};
        // A high nibble that wrapped past 15 needs the correction as well.
        if (nib_fix(hi[3:0], c_in) || hi[4]) begin
            hi = hi + {1'b0, `BCDADJ_NIB_FIX};
        end
        adj_calc = {hi[4], hi[3:0], lo[3:0]};
    endfunction : adj_calc

    // One subtractor feeds both the staged result and the stored byte.
    function automatic logic [7:0] dec_value(input logic [7:0] val);
        dec_value = val - 8'h01;
    endfunction : dec_value

    // Flags of a decrement in the order C, DC, N, OV, Z. Carry and digit
    // carry read as not-borrow, so each drops only when a borrow occurs.
    // Signed wrap can only happen when the most negative value is reduced.
    function automatic logic [4:0] dec_flags(input logic [7:0] val);
        logic [7:0] res;
        res = dec_value(val);
        dec_flags = {val != 8'h00, val[3:0] != 4'h0, res[7],
                     val == 8'h80, res == 8'h00};
    endfunction : dec_flags

    bcdadj_phase_gen u_phase (
        .clk(clk),
        .arst_n(arst_n),
        .phase(phase)
    );

    // The address is formed for every word, decrement or not. Only the
    // decrement and the words that decode to no operation read it, and a shared path keeps the decode shallow.
    // The quick-access bank ignores the pointer, so code that never sets
    // the pointer still reaches its most used bytes.
    always_comb begin
        next_mem_addr = mem_addr;
        if (opcode[`BCDADJ_BANK_BIT]) begin
            next_mem_addr = ADDR_W'({bank_pointer_register, opcode[7:0]});
        end else begin
            next_mem_addr = ADDR_W'({`BCDADJ_ACCESS_BANK, opcode[7:0]});
        end
    end

    // Decode in the first phase.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op <= BCDADJ_OP_NONE;
            dest_byte <= 1'b0;
            mem_addr <= '0;
        end else if (phase == BCDADJ_Q1) begin
            dest_byte <= opcode[`BCDADJ_DEST_BIT];
            mem_addr <= next_mem_addr;
            op <= decode_op(opcode);
        end
    end

    // Read the source in the second phase. The memory must answer for the
    // address registered at the decode edge within this one phase.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            operand <= 8'h00;
        end else if (phase == BCDADJ_Q2) begin
            if (op == BCDADJ_OP_ADJ) begin
                operand <= wreg;
            end else begin
                operand <= mem_rdata;
            end
        end
    end

    // The adjust answer is formed from the operand latched in the read
    // phase and from the flags as the previous instruction left them.
    always_comb begin
        adj_fix = adj_calc(operand, carry_flag,
                           digit_carry_flag);
    end

    // Compute in the third phase; flags are staged as C, DC, N, OV, Z.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result <= 8'h00;
            res_flags <= `BCDADJ_FLAGS_RST;
        end else if (phase == BCDADJ_Q3) begin
            if (op == BCDADJ_OP_ADJ) begin
                result <= adj_fix[7:0];
                // Carry is only ever set here, so a BCD carry chain over
                // several bytes is not broken by a byte without overflow.
                res_flags <= {adj_fix[8] | carry_flag, 4'h0};
            end else begin
                result <= dec_value(operand);
                res_flags <= dec_flags(operand);
            end
        end
    end

    always_comb begin
        next_mem_we = (phase == BCDADJ_Q3) && (op == BCDADJ_OP_DEC)
                      && dest_byte;
    end

    // Write back in the fourth phase. The strobe is registered from the
    // compute phase, so it is a clean one-cycle pulse inside the last
    // phase and never glitches while the phase counter changes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= next_mem_we;
            if (phase == BCDADJ_Q3 && op == BCDADJ_OP_DEC) begin
                mem_wdata <= dec_value(operand);
            end
        end
    end

    // The working register changes only at the end of an instruction, so
    // a following adjust always reads the value this one settled.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wreg <= `BCDADJ_W_RST;
        end else if (phase == BCDADJ_Q4) begin
            if (op == BCDADJ_OP_ADJ) begin
                wreg <= result;
            end else if (op == BCDADJ_OP_DEC && !dest_byte) begin
                wreg <= result;
            end
        end
    end

    // Status flags move together at the last phase. An unknown word
    // leaves them as they were, like the working register and memory.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {carry_flag, digit_carry_flag, negative_flag,
             signed_wrap_flag, zero_flag} <= `BCDADJ_FLAGS_RST;
        end else if (phase == BCDADJ_Q4) begin
            if (op == BCDADJ_OP_ADJ) begin
                carry_flag <= res_flags[4];
            end else if (op == BCDADJ_OP_DEC) begin
                {carry_flag, digit_carry_flag, negative_flag,
                 signed_wrap_flag, zero_flag} <= res_flags;
            end
        end
    end
endmodule : bcdadj_unit

// ===== testbench/bcdadj_unit_properties.sv
`timescale 1ns/10ps
`include "bcdadj_consts.svh"
module bcdadj_checker #(
    parameter int ADDR_W = 12 // Address width
) (
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic [15:0] opcode, // Opcode
    input wire logic [3:0] bank_pointer_register, // Bank
    input wire logic [7:0] mem_rdata, // Read data
    input wire logic [ADDR_W-1:0] mem_addr, // Address
    input wire logic mem_we, // Write strobe
    input wire logic [7:0] mem_wdata, // Write data
    input wire logic [7:0] wreg, // Working register
    input wire logic carry_flag, // Carry
    input wire logic digit_carry_flag, // Nibble carry
    input wire logic negative_flag, // Negative
    input wire logic signed_wrap_flag, // Overflow
    input wire logic zero_flag, // Zero
    input wire bcdadj_pkg::bcdadj_phase_e phase // Phase
);
    import bcdadj_pkg::*;
    logic q1;
    logic dec;
    logic adj;
    assign q1 = phase == BCDADJ_Q1;
    assign dec = q1 && opcode[15:10] == 6'h01;
    assign adj = q1 && opcode == `BCDADJ_OPC_ADJ;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_rest;
        phase == BCDADJ_Q2 ##1 phase == BCDADJ_Q3 ##1 phase == BCDADJ_Q4;
    endsequence
    sequence s_store;
        dec && opcode[`BCDADJ_DEST_BIT] ##3 1'b1;
    endsequence
    property p_phase; q1 |=> s_rest ##1 q1; endproperty
    a_phase: assert property (p_phase) else $error("phase order");
    property p_store;
        s_store |-> mem_we && mem_wdata == $past(mem_rdata, 2) - 8'h01;
    endproperty
    a_store: assert property (p_store) else $error("store");
    property p_we_only; mem_we |-> phase == BCDADJ_Q4; endproperty
    a_we_only: assert property (p_we_only) else $error("strobe");
    property p_addr;
        dec |=> mem_addr == {($past(opcode[8]) ? $past(bank_pointer_register)
            : `BCDADJ_ACCESS_BANK), $past(opcode[7:0])};
    endproperty
    a_addr: assert property (p_addr) else $error("address");
    property p_dec_flags;
        dec && !opcode[9] |=> ##3 zero_flag == (wreg == 8'h00) &&
            negative_flag == wreg[7] &&
            carry_flag == ($past(mem_rdata, 3) != 8'h00);
    endproperty
    a_dec_flags: assert property (p_dec_flags) else $error("flags");
    property p_adj_carry;
        adj |=> ##3 $stable(digit_carry_flag) &&
            (carry_flag || !$past(carry_flag));
    endproperty
    a_adj_carry: assert property (p_adj_carry) else $error("carry");
    property p_idle;
        q1 && !dec && !adj |=> ($stable(wreg) && !mem_we) [*4];
    endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_adj_low;
        adj |=> ##3 wreg[3:0] == $past(wreg[3:0], 4) +
            (($past(wreg[3:0], 4) > 4'h9 || $past(digit_carry_flag, 4))
            ? 4'h6 : 4'h0);
    endproperty
    a_adj_low: assert property (p_adj_low) else $error("low nibble");
endmodule : bcdadj_checker
bind bcdadj_unit bcdadj_checker #(.ADDR_W(ADDR_W)) bcdadj_checker_i (
    .clk(clk), .arst_n(arst_n), .opcode(opcode),
    .bank_pointer_register(bank_pointer_register), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .wreg(wreg), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .negative_flag(negative_flag), .signed_wrap_flag(signed_wrap_flag),
    .zero_flag(zero_flag), .phase(phase));

// ===== testbench/bcdadj_unit_tb.sv
`timescale 1ns/10ps
module bcdadj_unit_tb;
    import bcdadj_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] opc = 16'h0000;
    logic [3:0] bpr = 4'h0;
    logic [7:0] rd = 8'h00;
    logic [11:0] addr;
    logic we;
    logic [7:0] wd;
    logic [7:0] w;
    logic fc, fd, fn, fv, fz;
    logic [7:0] mw = 8'h00;
    logic mc = 1'b0, md = 1'b0, mn = 1'b0, mv = 1'b0, mz = 1'b0;
    bcdadj_phase_e phase;
    logic [33:0] eq[$];
    logic [33:0] mq[$];
    logic [20:0] cap;
    logic [7:0] rnd = 8'h63;
    int num_errors = 0;
    int comparisons = 0;
    bcdadj_unit bcdadj_unit_i (.clk(clk), .arst_n(arst_n), .opcode(opc),
        .bank_pointer_register(bpr), .mem_rdata(rd), .mem_addr(addr),
        .mem_we(we), .mem_wdata(wd), .wreg(w), .carry_flag(fc),
        .digit_carry_flag(fd), .negative_flag(fn), .signed_wrap_flag(fv),
        .zero_flag(fz), .phase(phase));
    initial forever #12.5 clk = ~clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic close_out;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // Expectations come from a model of the rules, kept in the queues.
    task automatic op(input logic [15:0] o, input logic [7:0] v);
        logic [8:0] t;
        logic [33:0] e;
        logic [33:0] m;
        do @(negedge clk); while (phase !== BCDADJ_Q1);
        rnd = lfsr(rnd);
        opc = o;
        rd = v;
        bpr = rnd[3:0];
        e = '0;
        m = 34'h3_fff0_0000;
        if (o == 16'h0007) begin
            t = {1'b0, mw};
            if (mw[3:0] > 4'h9 || md) t = t + 9'h006;
            if (t[7:4] > 4'h9 || mc || t[8]) t = t + 9'h060;
            mw = t[7:0];
            mc = mc | t[8];
        end else if (o[15:10] == 6'h01) begin
            t = {1'b0, v} - 9'h001;
            {mc, md, mn, mv} = {v != 8'h00, v[3:0] != 4'h0, t[7], v == 8'h80};
            mz = t[7:0] == 8'h00;
            if (!o[9]) mw = t[7:0];
            m = o[9] ? 34'h3_ffff_ffff : 34'h3_fff0_0fff;
            e[20:0] = {o[9], t[7:0], o[8] ? rnd[3:0] : 4'h0, o[7:0]};
        end
        e[33:21] = {mw, mc, md, mn, mv, mz};
        @(negedge clk);
        eq.push_back(e);
        mq.push_back(m);
    endtask : op
    always @(negedge clk) begin
        if (phase === BCDADJ_Q4) cap = {we, wd, addr};
        if (phase === BCDADJ_Q1 && eq.size() > 0) begin
            comparisons++;
            if (({w, fc, fd, fn, fv, fz, cap} & mq[0]) !== (eq[0] & mq[0])) begin
                num_errors++;
                $display("[ERR] t=%0t got=%h exp=%h", $time,
                    {w, fc, fd, fn, fv, fz, cap}, eq[0]);
            end
            eq.pop_front();
            mq.pop_front();
        end
    end
    initial begin
        #50000;
        num_errors++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        op(16'h0410, 8'ha6);
        op(16'h0610, 8'h00);
        op(16'h0007, 8'h00);
        op(16'h0410, 8'hcf);
        op(16'h0710, 8'h00);
        op(16'h0007, 8'h00);
        op(16'h0580, 8'h80);
        op(16'h1007, 8'h00);
        op(16'h0017, 8'h00);
        $display("fixed cases done");
        for (int i = 0; i < 40; i++) begin
            op({6'h01, rnd[2:1], rnd ^ 8'h5a}, rnd);
            op(16'h0007, 8'h00);
        end
        repeat (8) @(negedge clk);
        $display("random cases done");
        close_out();
    end
endmodule : bcdadj_unit_tb
